// File: core/host_port_pkg.sv
// Package with constants and carrier types for the host bus slave port.
package host_port_pkg;

  // ****************************************************************
  // Widths and encodings
  // ****************************************************************
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LANES  = 4;

  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;
  localparam logic [1:0] SIZE_WORD = 2'h0;

  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // Cycles to wait for the system bus before forcing a retry.
  localparam logic [7:0] SYS_TIMEOUT_CYC = 8'h40;

  // Reset values of outputs.
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [LANES-1:0]  PAR_RST  = 4'h0;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              read;
    logic [1:0]        size;
    logic              burst_n;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  wpar;
  } host_req_t;

  typedef struct packed {
    logic              req;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
    logic [DATA_W-1:0] wdata;
  } sys_req_t;

  typedef struct packed {
    logic              done;
    logic              error;
    logic              retry;
    logic [DATA_W-1:0] rdata;
  } sys_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_RESP = 2'b11,
    ST_HOLD = 2'b10
  } state_t;

endpackage

// File: core/lane_parity.sv
// Per-lane even parity generator and lane enable decoder.
`timescale 1ns/10ps
module lane_parity (
  input  wire logic [31:0] data,
  input  wire logic [1:0]  width_sel,
  output logic      [3:0]  lane_en,
  output logic      [3:0]  parity
);

  // ****************************************************************
  // Lane parity
  // ****************************************************************
  // One parity bit per byte lane, zero for lanes outside the width.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign parity[g] = lane_en[g] & (^data[8*g +: 8]);
    end
  endgenerate

  // Lane enables follow the selected bus width.
  assign lane_en = (width_sel == host_port_pkg::WIDTH_8)  ? 4'h1 :
                   (width_sel == host_port_pkg::WIDTH_16) ? 4'h3 :
                   4'hf;

endmodule

// File: core/host_port.sv
// Host bus slave port bridging an external master to the system bus.
`timescale 1ns/10ps
module host_port (
  input  wire logic                          host_bus_clock,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  input  wire logic                          port_enable,
  input  wire logic [1:0]                    width_sel,
  input  wire logic                          chip_select_low_n,
  input  wire logic                          chip_select_high,
  input  wire logic                          transfer_strobe_n,
  input  wire logic                          read_write_select,
  input  wire logic [1:0]                    transfer_size,
  input  wire logic                          burst_n,
  input  wire logic [17:0]                   host_addr,
  input  wire logic [31:0]                   host_data_in,
  output logic      [31:0]                   host_data_out,
  output logic      [31:0]                   host_data_oe,
  input  wire logic [3:0]                    host_parity_in,
  output logic      [3:0]                    host_parity_out,
  output logic      [3:0]                    host_parity_oe,
  output logic                               transfer_ack_n,
  output logic                               transfer_error_ack_n,
  output logic                               retry_request_n,
  output logic                               parity_error,
  output logic                               sys_clk,
  output host_port_pkg::sys_req_t            sys_req,
  input  wire host_port_pkg::sys_rsp_t       sys_rsp
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Byte enables for the requested size, aligned by the low address.
  function automatic logic [3:0] size_be(input logic [1:0] sz,
                                         input logic [1:0] a);
    logic [3:0] be;
    be = 4'h0;
    case (sz)
      host_port_pkg::SIZE_BYTE: be = 4'h1 << a;
      host_port_pkg::SIZE_HALF: be = a[1] ? 4'hc : 4'h3;
      host_port_pkg::SIZE_WORD: be = 4'hf;
      default:                  be = 4'hf;
    endcase
    return be;
  endfunction

  // Spread a lane enable over the eight bits of each byte lane. Both the
  // write masking and the read drivers use it, so they cannot disagree.
  function automatic logic [31:0] lane_mask(input logic [3:0] en);
    lane_mask = {{8{en[3]}}, {8{en[2]}}, {8{en[1]}}, {8{en[0]}}};
  endfunction

  // Selection needs both selects true together while the port is used.
  wire selected = port_enable & ~chip_select_low_n & chip_select_high
                  & ~transfer_strobe_n;
  wire [3:0] lane_en;
  wire [3:0] wpar_calc;
  wire [3:0] rpar_calc;
  wire [3:0] req_be = size_be(transfer_size, host_addr[1:0]);

  // The system bus shares the host clock; there is no crossing.
  assign sys_clk = host_bus_clock;

  // ****************************************************************
  // State
  // ****************************************************************
  host_port_pkg::state_t     state_q, state_d;
  host_port_pkg::sys_req_t   req_q, req_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      reading_q, reading_d;
  logic                      ack_q, ack_d;
  logic                      tea_q, tea_d;
  logic                      rty_q, rty_d;
  logic                      perr_q, perr_d;
  logic [7:0]                tmo_q, tmo_d;

  lane_parity u_wpar (
    .data      (host_data_in),
    .width_sel (width_sel),
    .lane_en   (lane_en),
    .parity    (wpar_calc)
  );

  lane_parity u_rpar (
    .data      (rdata_q),
    .width_sel (width_sel),
    .lane_en   (),
    .parity    (rpar_calc)
  );

  // Next state. A single response flag is raised per transaction, and
  // the hold state waits for the strobe to rise, unless burst_n is low, so that one long strobe
  // is not taken twice.
  always_comb begin
    state_d   = state_q;
    req_d     = req_q;
    rdata_d   = rdata_q;
    reading_d = reading_q;
    ack_d     = 1'b0;
    tea_d     = 1'b0;
    rty_d     = 1'b0;
    perr_d    = perr_q;
    tmo_d     = tmo_q;
    case (state_q)
      host_port_pkg::ST_IDLE: begin
        reading_d = 1'b0;
        if (selected) begin
          req_d.req   = 1'b1;
          req_d.write = ~read_write_select;
          req_d.addr  = host_addr;
          req_d.be    = req_be & lane_en;
          req_d.wdata = host_data_in & lane_mask(lane_en);
          perr_d      = ~read_write_select &
                        ((wpar_calc ^ host_parity_in) & lane_en) != 4'h0;
          tmo_d       = host_port_pkg::SYS_TIMEOUT_CYC;
          state_d     = host_port_pkg::ST_BUSY;
        end
      end
      host_port_pkg::ST_BUSY: begin
        req_d.req = 1'b0;
        tmo_d     = tmo_q - 8'h01;
        if (sys_rsp.done | sys_rsp.error | sys_rsp.retry
            | tmo_q == 8'h00) begin
          state_d = host_port_pkg::ST_RESP;
          if (sys_rsp.error) begin
            tea_d = 1'b1;
          end else if (sys_rsp.retry | ~sys_rsp.done) begin
            rty_d = 1'b1;
          end else begin
            ack_d     = 1'b1;
            rdata_d   = sys_rsp.rdata;
            reading_d = ~req_q.write;
          end
        end
      end
      host_port_pkg::ST_RESP: begin
        reading_d = 1'b0;
        state_d   = host_port_pkg::ST_HOLD;
      end
      host_port_pkg::ST_HOLD: begin
        // A burst may issue its next beat while the strobe stays low.
        if (transfer_strobe_n | ~burst_n) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  // Registers, all updated on the rising host clock.
  always_ff @(posedge host_bus_clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= host_port_pkg::ST_IDLE;
      req_q     <= '0;
      rdata_q   <= host_port_pkg::DATA_RST;
      reading_q <= 1'b0;
      ack_q     <= 1'b0;
      tea_q     <= 1'b0;
      rty_q     <= 1'b0;
      perr_q    <= 1'b0;
      tmo_q     <= 8'h00;
    end else if (clk_en) begin
      state_q   <= state_d;
      req_q     <= req_d;
      rdata_q   <= rdata_d;
      reading_q <= reading_d;
      ack_q     <= ack_d;
      tea_q     <= tea_d;
      rty_q     <= rty_d;
      perr_q    <= perr_d;
      tmo_q     <= tmo_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Read data is driven only during the acknowledge cycle of a read,
  // and only on the lanes of the selected width.
  assign host_data_out   = rdata_q;
  assign host_data_oe    = lane_mask({4{reading_q}} & lane_en);
  assign host_parity_out = rpar_calc;
  assign host_parity_oe  = {4{reading_q}} & lane_en;
  assign transfer_ack_n       = ~ack_q;
  assign transfer_error_ack_n = ~tea_q;
  assign retry_request_n      = ~rty_q;
  assign parity_error    = perr_q;
  assign sys_req         = req_q;

endmodule

// File: bench/host_port_props.sv
// Concurrent checks on the host bus slave port pins.
`timescale 1ns/10ps
module host_port_props (
  input wire logic                    host_bus_clock,
  input wire logic                    resetn,
  input wire logic                    port_enable,
  input wire logic [1:0]              width_sel,
  input wire logic [31:0]             host_data_out,
  input wire logic [31:0]             host_data_oe,
  input wire logic [3:0]              host_parity_out,
  input wire logic [3:0]              host_parity_oe,
  input wire logic                    transfer_ack_n,
  input wire logic                    transfer_error_ack_n,
  input wire logic                    retry_request_n,
  input wire host_port_pkg::sys_req_t sys_req,
  input wire host_port_pkg::sys_rsp_t sys_rsp
);
  // ********
  // Checks
  // ********
  default clocking @(posedge host_bus_clock); endclocking
  default disable iff (!resetn);
  // Lane views of the outputs; width 2 and 3 both mean all lanes.
  wire [2:0]  lo = ~{transfer_ack_n, transfer_error_ack_n, retry_request_n};
  wire [31:0] d  = host_data_out;
  wire [3:0]  pv = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  wire [31:0] m  = width_sel == 2'h0 ? 32'hff :
                   width_sel == 2'h1 ? 32'hffff : '1;
  a_one_resp: assert property ($countones(lo) <= 1)
    else $error("two responses at once");
  a_resp_bound: assert property (sys_req.req |-> ##[1:80] lo != 0)
    else $error("request left unanswered");
  a_ack_done: assert property ($rose(sys_rsp.done) && !sys_rsp.error
    && !sys_rsp.retry |-> ##[1:3] !transfer_ack_n) else $error("no ack");
  a_err_done: assert property ($rose(sys_rsp.done) && sys_rsp.error
    |-> ##[1:3] !transfer_error_ack_n) else $error("no error ack");
  a_rty_done: assert property ($rose(sys_rsp.done) && sys_rsp.retry
    && !sys_rsp.error |-> ##[1:3] !retry_request_n) else $error("no retry");
  a_drive_ack: assert property (host_data_oe != 0 |-> !transfer_ack_n)
    else $error("data driven outside ack");
  a_lane_gate: assert property ((host_data_oe & ~m) == 0)
    else $error("lane beyond width driven");
  a_par_lane: assert property ((pv & host_parity_oe) ==
    (host_parity_out & host_parity_oe)) else $error("lane parity wrong");
  a_port_off: assert property (!port_enable |-> lo == 0 &&
    host_data_oe == 0) else $error("unused port answered");
  cover property (!transfer_ack_n);
  cover property (!transfer_error_ack_n);
  cover property (!retry_request_n);
endmodule
bind host_port host_port_props u_props (.*);

// File: bench/host_master.sv
// Bus master model that drives the host side of the slave port.
`timescale 1ns/10ps
module host_master (
  input  wire logic        host_bus_clock,
  input  wire logic        transfer_ack_n,
  input  wire logic        transfer_error_ack_n,
  input  wire logic        retry_request_n,
  input  wire logic [31:0] host_data_out,
  output logic             chip_select_low_n,
  output logic             chip_select_high,
  output logic             transfer_strobe_n,
  output logic             read_write_select,
  output logic [1:0]       transfer_size,
  output logic             burst_n,
  output logic [17:0]      host_addr,
  output logic [31:0]      host_data_in,
  output logic [3:0]       host_parity_in
);
  // ********
  // Transfers
  // ********
  // Idle bus: deselected, single beats only.
  initial begin
    {chip_select_low_n, transfer_strobe_n, read_write_select} = 3'h7;
    {chip_select_high, transfer_size, host_addr} = '0;
    {host_data_in, host_parity_in} = '0;
    burst_n = 1'b1;
  end
  // Qualifiers hold until an answer is sampled, so a slow port never sees
  // them move; on reads the data lines carry junk, not the last value.
  task automatic xfer(input logic r, input logic [1:0] s,
                      input logic [31:0] dw, input logic [3:0] p,
                      output logic [1:0] c, output logic [31:0] q);
    c = 2'h0;
    q = '0;
    @(posedge host_bus_clock);
    {chip_select_low_n, chip_select_high} <= 2'h1;
    transfer_strobe_n <= 1'b0;
    read_write_select <= r;
    transfer_size <= s;
    host_addr <= 18'h00100;
    host_data_in <= r ? ~host_data_in : dw;
    host_parity_in <= r ? ~host_parity_in : p;
    for (int i = 0; i < 90 && c == 2'h0; i++) begin
      @(posedge host_bus_clock);
      c = !transfer_error_ack_n ? 2'h2 : !retry_request_n ? 2'h3 :
          !transfer_ack_n ? 2'h1 : 2'h0;
      q = host_data_out;
    end
    // Any answer, a retry too, ends the cycle and frees the bus.
    {chip_select_low_n, chip_select_high, transfer_strobe_n} <= 3'h5;
  endtask
endmodule

// File: bench/tb_host_port.sv
// Self-checking testbench for the host bus slave port.
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module tb_host_port;
  // ********
  // Stimulus
  // ********
  localparam logic [31:0] RD = 32'h3c5a_a5c3;
  logic        host_bus_clock = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic        port_enable = 1'b1, err = 1'b0, rty = 1'b0;
  logic        chip_select_low_n, chip_select_high, transfer_strobe_n;
  logic        read_write_select, burst_n, parity_error, sys_clk;
  logic        transfer_ack_n, transfer_error_ack_n, retry_request_n;
  logic [1:0]  width_sel = 2'h2, transfer_size, c;
  logic [17:0] host_addr;
  logic [31:0] host_data_in, host_data_out, host_data_oe, q;
  logic [3:0]  host_parity_in, host_parity_out, host_parity_oe;
  int          error_cnt = 0, total_checks = 0, nreq = 0, lat = 1;
  host_port_pkg::sys_req_t sys_req, got;
  host_port_pkg::sys_rsp_t sys_rsp = '0;
  host_port u_dut (.*);
  host_master u_mst (.*);
  always #5 host_bus_clock = ~host_bus_clock;
  // System bus stand-in: answers after lat cycles and holds the answer
  // until a response shows, five cycles at most; a lat of 99 leaves it unanswered.
  always @(posedge host_bus_clock) begin
    if (sys_req.req) begin
      got <= sys_req;
      nreq <= nreq + 1;
      repeat (lat) @(posedge host_bus_clock);
      if (lat < 99) begin
        sys_rsp <= '{1'b1, err, rty, RD};
        for (int i = 0; i < 5 && transfer_ack_n && transfer_error_ack_n
             && retry_request_n; i++) @(posedge host_bus_clock);
        sys_rsp <= '{1'b0, 1'b0, 1'b0, ~RD};
      end
    end
  end
  // Even parity per byte lane, lane 0 in bit 0.
  function automatic logic [3:0] par(input logic [31:0] v);
    return {^v[31:24], ^v[23:16], ^v[15:8], ^v[7:0]};
  endfunction
  // One transfer; silence where an answer is due ends the run.
  task automatic go(input logic r, input logic [1:0] s,
                    input logic [31:0] v, input logic [3:0] p,
                    input logic [1:0] e);
    u_mst.xfer(r, s, v, p, c, q);
    `CHK(c, e)
    if (c == 2'h0 && e != 2'h0) stop_test();
  endtask
  task automatic t_write();
    for (int k = 0; k < 2; k++) begin
      go(1'b0, 2'h0, 32'h1234_5678, par(32'h1234_5678) ^ k[3:0], 2'h1);
      `CHK(got.write, 1'b1)
      `CHK(got.be, 4'hf)
      `CHK(got.wdata, 32'h1234_5678)
      `CHK(parity_error, k[0])
    end
  endtask
  task automatic t_read();
    logic [1:0] sz [3] = '{2'h1, 2'h2, 2'h0};
    for (int i = 0; i < 3; i++) begin
      lat = i * 3 + 1;
      go(1'b1, sz[i], 32'h0, 4'h0, 2'h1);
      `CHK(q, RD)
      `CHK(got.write, 1'b0)
      `CHK($countones(got.be), 1 << i)
    end
    lat = 1;
  endtask
  task automatic t_width();
    for (int w = 0; w < 2; w++) begin
      width_sel <= w[1:0];
      go(1'b0, 2'h0, 32'hffff_ffff, 4'h0, 2'h1);
      `CHK(got.be, w ? 4'h3 : 4'h1)
      `CHK(got.wdata, w ? 32'hffff : 32'hff)
      go(1'b1, 2'h0, 32'h0, 4'h0, 2'h1);
    end
    width_sel <= 2'h2;
  endtask
  // Error beats retry; a silent system bus times out into a retry.
  task automatic t_resp();
    logic [1:0] m [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic [1:0] e [4] = '{2'h2, 2'h3, 2'h2, 2'h3};
    for (int i = 0; i < 4; i++) begin
      {err, rty} = m[i];
      lat = i == 3 ? 99 : 2;
      go(1'b0, 2'h0, 32'h0, 4'h0, e[i]);
      repeat (40) @(posedge host_bus_clock);
    end
    {err, rty} = 2'h0;
    lat = 1;
  endtask
  task automatic t_off();
    int n;
    n = nreq;
    port_enable <= 1'b0;
    go(1'b0, 2'h0, 32'h0, 4'h0, 2'h0);
    `CHK(nreq, n)
    port_enable <= 1'b1;
    clk_en <= 1'b0;
    go(1'b0, 2'h0, 32'h0, 4'h0, 2'h0);
    `CHK(nreq, n)
    clk_en <= 1'b1;
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge host_bus_clock);
    resetn <= 1'b1;
    t_write();
    t_read();
    t_width();
    t_resp();
    t_off();
    stop_test();
  end
endmodule
